/* common/bit_link_if.sv */
// Synchronised bus levels and events passed from the line sampler to the decoder.
`timescale 1ns/10ps
interface bit_link_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic start;
  logic stop;
  modport src(output scl, output sda, output scl_rise, output start, output stop);
  modport dst(input scl, input sda, input scl_rise, input start, input stop);
endinterface : bit_link_if

/* common/i2c_mon_pkg.sv */
// Shared constants and types for the I2C bus trigger decoder.
package i2c_mon_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths.
  localparam int unsigned APB_AW = 8;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned PAT_BYTES = 3;
  localparam int unsigned PAT_W = 24;
  localparam int unsigned TGT_W = 10;
  localparam int unsigned OFF_W = 12;
  localparam int unsigned CNT_W = 13;
  localparam int unsigned TS_W = 32;
  localparam int unsigned CTRL_W = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TARGET = 8'h04;
  localparam logic [7:0] OFS_OFFSET = 8'h08;
  localparam logic [7:0] OFS_PVAL = 8'h0c;
  localparam logic [7:0] OFS_PMASK = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_REC0 = 8'h18;
  localparam logic [7:0] OFS_REC1 = 8'h1c;
  localparam logic [7:0] OFS_REC2 = 8'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Control fields and reset value.
  localparam int CTRL_MODE_LO = 0;
  localparam int CTRL_MODE_HI = 2;
  localparam int CTRL_TEN = 3;
  localparam int CTRL_READ = 4;
  localparam int CTRL_DATA = 5;
  localparam int CTRL_INCL_RW = 6;
  localparam int CTRL_CNT_LO = 7;
  localparam int CTRL_CNT_HI = 8;
  localparam int CTRL_HEX = 9;
  localparam logic [9:0] CTRL_RESET = 10'h080;
  localparam logic [1:0] CNT_MIN = 2'h1;
  localparam logic [1:0] CNT_MAX = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger conditions.
  localparam logic [2:0] MODE_START = 3'h0;
  localparam logic [2:0] MODE_STOP = 3'h1;
  localparam logic [2:0] MODE_RESTART = 3'h2;
  localparam logic [2:0] MODE_NACK = 3'h3;
  localparam logic [2:0] MODE_ADDR = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Frame status codes and record layout.
  localparam logic [1:0] CODE_OK = 2'h0;
  localparam logic [1:0] CODE_NO_DATA = 2'h1;
  localparam logic [1:0] CODE_ADDR_ERR = 2'h2;
  localparam logic [1:0] CODE_PARTIAL = 2'h3;
  localparam int REC_CODE_LO = 0;
  localparam int REC_DIR = 2;
  localparam int REC_TEN = 3;
  localparam int REC_ADDR_LO = 4;
  localparam int REC_CNT_LO = 14;
  localparam int STAT_ACTIVE = 0;
  localparam int STAT_VALID = 1;
  localparam int STAT_TRIG_LO = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Bus protocol constants.
  localparam logic [3:0] LAST_DATA_BIT = 4'h8;
  localparam logic [4:0] TEN_PREFIX = 5'h1e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ADDR = 3'b010,
    ST_DATA = 3'b100
  } frame_e;

endpackage : i2c_mon_pkg

/* design/i2c_bus_trigger_decoder.sv */
// Passive I2C bus monitor: condition triggers, address/data match, frame records.
`timescale 1ns/10ps
module i2c_bus_trigger_decoder (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [i2c_mon_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Observed bus
  input wire logic scl_in,
  input wire logic sda_in,
  // Acquisition window from the capture logic
  input wire logic capture_active,
  // Results
  output logic trigger,
  output logic record_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  typedef struct packed {
    i2c_mon_pkg::frame_e fsm;
    logic [i2c_mon_pkg::CTRL_W-1:0] ctrl;
    logic [i2c_mon_pkg::TGT_W-1:0] target;
    logic [i2c_mon_pkg::OFF_W-1:0] offset;
    logic [i2c_mon_pkg::PAT_W-1:0] pval;
    logic [i2c_mon_pkg::PAT_W-1:0] pmask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic seen;
    logic ten;
    logic addr_done;
    logic addr_ok;
    logic dir;
    logic [i2c_mon_pkg::TGT_W-1:0] addr;
    logic [i2c_mon_pkg::CNT_W-1:0] data_cnt;
    logic [i2c_mon_pkg::PAT_W-1:0] window;
    logic cap_start;
    logic [i2c_mon_pkg::TS_W-1:0] ts;
    logic [i2c_mon_pkg::TS_W-1:0] start_ts;
    logic [i2c_mon_pkg::TS_W-1:0] trig_ts;
    logic [1:0] rec_code;
    logic rec_dir;
    logic rec_ten;
    logic [i2c_mon_pkg::TGT_W-1:0] rec_addr;
    logic [i2c_mon_pkg::CNT_W-1:0] rec_cnt;
    logic [i2c_mon_pkg::PAT_W-1:0] rec_data;
    logic [i2c_mon_pkg::TS_W-1:0] rec_time;
    logic rec_valid;
    logic trigger;
    logic [7:0] trig_count;
  } main_s;

  main_s q;
  main_s next_q;

  bit_link_if link ();

  logic pat_ok;
  logic [i2c_mon_pkg::PAT_W-1:0] next_window;

  ////////////////////////////////////////////////////////////////////////////
  // Functions.
  function automatic logic mapped(input logic [i2c_mon_pkg::APB_AW-1:0] a);
    mapped = a inside {i2c_mon_pkg::OFS_CTRL, i2c_mon_pkg::OFS_TARGET,
                       i2c_mon_pkg::OFS_OFFSET, i2c_mon_pkg::OFS_PVAL,
                       i2c_mon_pkg::OFS_PMASK, i2c_mon_pkg::OFS_STATUS,
                       i2c_mon_pkg::OFS_REC0, i2c_mon_pkg::OFS_REC1,
                       i2c_mon_pkg::OFS_REC2};
  endfunction : mapped

  function automatic logic [1:0] clamp_count(input logic [1:0] c);
    clamp_count = (c < i2c_mon_pkg::CNT_MIN) ? i2c_mon_pkg::CNT_MIN : c;
  endfunction : clamp_count

  ////////////////////////////////////////////////////////////////////////////
  // Submodules.
  // Both pins pass two flip-flops before any decoding logic reads them.
  line_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .link(link.src)
  );

  assign next_window = {q.window[i2c_mon_pkg::PAT_W-9:0], q.shreg};

  pattern_match u_match (
    .window(next_window),
    .value(q.pval),
    .care(q.pmask),
    .hex_mode(q.ctrl[i2c_mon_pkg::CTRL_HEX]),
    .byte_count(q.ctrl[i2c_mon_pkg::CTRL_CNT_HI:i2c_mon_pkg::CTRL_CNT_LO]),
    .match(pat_ok)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    logic fire;
    logic close;
    logic [2:0] mode;
    logic [7:0] unit;
    logic hit7;
    logic hit10;
    logic dir_ok;
    logic [i2c_mon_pkg::CNT_W-1:0] last_idx;
    logic partial;
    fire = 1'b0;
    close = 1'b0;
    mode = q.ctrl[i2c_mon_pkg::CTRL_MODE_HI:i2c_mon_pkg::CTRL_MODE_LO];
    unit = {q.shreg[6:0], link.sda};
    hit7 = q.target[6:0] == q.shreg[7:1];
    hit10 = q.target == {q.addr[9:8], q.shreg};
    dir_ok = q.dir == q.ctrl[i2c_mon_pkg::CTRL_READ];
    last_idx = i2c_mon_pkg::CNT_W'(q.offset)
             + i2c_mon_pkg::CNT_W'(q.ctrl[i2c_mon_pkg::CTRL_CNT_HI:i2c_mon_pkg::CTRL_CNT_LO])
             - i2c_mon_pkg::CNT_W'(1);
    // A frame is cut when it opened or closes outside the capture window.
    partial = !q.cap_start || !capture_active;
    next_q = q;
    next_q.ts = q.ts + i2c_mon_pkg::TS_W'(1);
    next_q.trigger = 1'b0;

    // APB: answer one cycle into the access phase, act on the completing edge.
    next_q.pready = 1'b0;
    next_q.pslverr = 1'b0;
    if (psel && penable && !q.pready) begin
      next_q.pready = 1'b1;
      next_q.pslverr = !mapped(paddr);
      // Write answers leave prdata alone, so it holds the last read value.
      if (!pwrite) begin
        next_q.prdata = 32'h0;
        unique case (paddr)
          i2c_mon_pkg::OFS_CTRL: next_q.prdata[i2c_mon_pkg::CTRL_W-1:0] = q.ctrl;
          i2c_mon_pkg::OFS_TARGET: next_q.prdata[i2c_mon_pkg::TGT_W-1:0] = q.target;
          i2c_mon_pkg::OFS_OFFSET: next_q.prdata[i2c_mon_pkg::OFF_W-1:0] = q.offset;
          i2c_mon_pkg::OFS_PVAL: next_q.prdata[i2c_mon_pkg::PAT_W-1:0] = q.pval;
          i2c_mon_pkg::OFS_PMASK: next_q.prdata[i2c_mon_pkg::PAT_W-1:0] = q.pmask;
          i2c_mon_pkg::OFS_STATUS: begin
            next_q.prdata[i2c_mon_pkg::STAT_ACTIVE] = q.fsm != i2c_mon_pkg::ST_IDLE;
            next_q.prdata[i2c_mon_pkg::STAT_VALID] = q.rec_valid;
            next_q.prdata[i2c_mon_pkg::STAT_TRIG_LO +: 8] = q.trig_count;
          end
          i2c_mon_pkg::OFS_REC0: begin
            next_q.prdata[i2c_mon_pkg::REC_CODE_LO +: 2] = q.rec_code;
            next_q.prdata[i2c_mon_pkg::REC_DIR] = q.rec_dir;
            next_q.prdata[i2c_mon_pkg::REC_TEN] = q.rec_ten;
            next_q.prdata[i2c_mon_pkg::REC_ADDR_LO +: i2c_mon_pkg::TGT_W] = q.rec_addr;
            next_q.prdata[i2c_mon_pkg::REC_CNT_LO +: i2c_mon_pkg::CNT_W] = q.rec_cnt;
          end
          i2c_mon_pkg::OFS_REC1: next_q.prdata[i2c_mon_pkg::PAT_W-1:0] = q.rec_data;
          i2c_mon_pkg::OFS_REC2: next_q.prdata = q.rec_time;
          default: next_q.prdata = 32'h0;
        endcase
      end
    end
    if (psel && penable && q.pready) begin
      if (pwrite) begin
        unique case (paddr)
          i2c_mon_pkg::OFS_CTRL: begin
            next_q.ctrl = pwdata[i2c_mon_pkg::CTRL_W-1:0];
            next_q.ctrl[i2c_mon_pkg::CTRL_CNT_HI:i2c_mon_pkg::CTRL_CNT_LO] =
              clamp_count(pwdata[i2c_mon_pkg::CTRL_CNT_HI:i2c_mon_pkg::CTRL_CNT_LO]);
          end
          i2c_mon_pkg::OFS_TARGET: next_q.target = pwdata[i2c_mon_pkg::TGT_W-1:0];
          i2c_mon_pkg::OFS_OFFSET: next_q.offset = pwdata[i2c_mon_pkg::OFF_W-1:0];
          i2c_mon_pkg::OFS_PVAL: next_q.pval = pwdata[i2c_mon_pkg::PAT_W-1:0];
          i2c_mon_pkg::OFS_PMASK: next_q.pmask = pwdata[i2c_mon_pkg::PAT_W-1:0];
          default: next_q.pmask = q.pmask;
        endcase
      end else if (paddr == i2c_mon_pkg::OFS_REC2) begin
        // Reading the last record word releases the record.
        next_q.rec_valid = 1'b0;
      end
    end

    // Bus conditions and bit decoding.
    if (link.start) begin
      // Every start counts as a frame start, a repeated one as well.
      fire = mode == i2c_mon_pkg::MODE_START;
      if (q.fsm != i2c_mon_pkg::ST_IDLE) begin
        // A start inside an open frame closes it and is a repeated start.
        close = 1'b1;
        fire = fire || mode == i2c_mon_pkg::MODE_RESTART;
      end
    end else if (link.stop) begin
      fire = mode == i2c_mon_pkg::MODE_STOP;
      close = q.fsm != i2c_mon_pkg::ST_IDLE;
      next_q.fsm = i2c_mon_pkg::ST_IDLE;
    end else if (link.scl_rise && q.fsm != i2c_mon_pkg::ST_IDLE) begin
      // The clock rise that leads into a stop looks like a bit as well, so a
      // bit only counts as decoded once a later rise has followed it.
      if (q.bit_cnt != 4'h0) begin
        next_q.seen = 1'b1;
      end
      if (q.bit_cnt < i2c_mon_pkg::LAST_DATA_BIT) begin
        next_q.shreg = unit;
        next_q.bit_cnt = q.bit_cnt + 4'h1;
      end else begin
        // Ninth bit: acknowledge slot, the byte in shreg is complete.
        next_q.bit_cnt = 4'h0;
        if (link.sda && mode == i2c_mon_pkg::MODE_NACK) begin
          fire = 1'b1;
        end
        if (q.fsm == i2c_mon_pkg::ST_ADDR) begin
          if (!q.ten) begin
            next_q.dir = q.shreg[0];
            dir_ok = q.shreg[0] == q.ctrl[i2c_mon_pkg::CTRL_READ];
            if (q.ctrl[i2c_mon_pkg::CTRL_TEN] && q.shreg[7:3] == i2c_mon_pkg::TEN_PREFIX) begin
              next_q.ten = 1'b1;
              next_q.addr = {q.shreg[2:1], 8'h00};
            end else begin
              if (q.ctrl[i2c_mon_pkg::CTRL_INCL_RW]) begin
                next_q.addr = {2'h0, q.shreg};
              end else begin
                next_q.addr = {3'h0, q.shreg[7:1]};
              end
              next_q.addr_done = 1'b1;
              next_q.addr_ok = hit7 && dir_ok;
              next_q.fsm = i2c_mon_pkg::ST_DATA;
            end
          end else begin
            next_q.addr = {q.addr[9:8], q.shreg};
            next_q.addr_done = 1'b1;
            next_q.addr_ok = hit10 && dir_ok;
            next_q.fsm = i2c_mon_pkg::ST_DATA;
          end
          if (next_q.addr_done && next_q.addr_ok && mode == i2c_mon_pkg::MODE_ADDR &&
              !q.ctrl[i2c_mon_pkg::CTRL_DATA]) begin
            fire = 1'b1;
          end
        end else begin
          next_q.window = next_window;
          if (q.data_cnt != {i2c_mon_pkg::CNT_W{1'b1}}) begin
            next_q.data_cnt = q.data_cnt + i2c_mon_pkg::CNT_W'(1);
          end
          if (mode == i2c_mon_pkg::MODE_ADDR && q.ctrl[i2c_mon_pkg::CTRL_DATA] &&
              q.addr_ok && q.data_cnt == last_idx && pat_ok) begin
            fire = 1'b1;
          end
        end
      end
    end

    if (fire) begin
      next_q.trigger = 1'b1;
      next_q.trig_ts = q.ts;
      next_q.trig_count = q.trig_count + 8'h01;
    end

    // Frame record; a new record wins over a clearing read in the same cycle.
    if (close) begin
      next_q.rec_valid = 1'b1;
      next_q.rec_time = q.start_ts - (fire ? q.ts : q.trig_ts);
      next_q.rec_dir = q.dir;
      next_q.rec_ten = q.ten;
      next_q.rec_addr = q.addr;
      next_q.rec_cnt = q.data_cnt;
      next_q.rec_data = q.window;
      if (partial && !q.seen) begin
        next_q.rec_code = i2c_mon_pkg::CODE_NO_DATA;
      end else if (partial) begin
        next_q.rec_code = i2c_mon_pkg::CODE_PARTIAL;
      end else if (!q.addr_done) begin
        next_q.rec_code = i2c_mon_pkg::CODE_ADDR_ERR;
      end else begin
        next_q.rec_code = i2c_mon_pkg::CODE_OK;
      end
    end

    // Open a new frame on any start, including a repeated one.
    if (link.start) begin
      next_q.fsm = i2c_mon_pkg::ST_ADDR;
      next_q.bit_cnt = 4'h0;
      next_q.seen = 1'b0;
      next_q.ten = 1'b0;
      next_q.addr_done = 1'b0;
      next_q.addr_ok = 1'b0;
      next_q.dir = 1'b0;
      next_q.addr = '0;
      next_q.data_cnt = '0;
      next_q.window = '0;
      next_q.start_ts = q.ts;
      next_q.cap_start = capture_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.fsm <= i2c_mon_pkg::ST_IDLE;
      q.ctrl <= i2c_mon_pkg::CTRL_RESET;
    end else begin
      q <= next_q;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign trigger = q.trigger;
  assign record_valid = q.rec_valid;

endmodule : i2c_bus_trigger_decoder

/* design/line_sync.sv */
// Two-stage synchroniser for SCL and SDA with start, stop and clock edge detection.
`timescale 1ns/10ps
module line_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Observed bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  // Cleaned levels and events
  bit_link_if.src link
);

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
  } sync_s;

  sync_s q;
  sync_s next_q;

  always_comb begin
    next_q = q;
    next_q.scl_m = scl_in;
    next_q.scl_s = q.scl_m;
    next_q.scl_p = q.scl_s;
    next_q.sda_m = sda_in;
    next_q.sda_s = q.sda_m;
    next_q.sda_p = q.sda_s;
  end

  // An idle bus floats high, so the chain resets to ones.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '1;
    end else begin
      q <= next_q;
    end
  end

  assign link.scl = q.scl_s;
  assign link.sda = q.sda_s;
  assign link.scl_rise = q.scl_s & ~q.scl_p;
  assign link.start = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
  assign link.stop = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;

endmodule : line_sync

/* design/pattern_match.sv */
// Three-state byte pattern comparator over the most recent data bytes.
`timescale 1ns/10ps
module pattern_match (
  // Data window, newest byte lowest
  input wire logic [i2c_mon_pkg::PAT_W-1:0] window,
  // Pattern value and care mask
  input wire logic [i2c_mon_pkg::PAT_W-1:0] value,
  input wire logic [i2c_mon_pkg::PAT_W-1:0] care,
  input wire logic hex_mode,
  input wire logic [1:0] byte_count,
  // Result
  output logic match
);

  // In hex entry a byte is either fully cared for or fully ignored.
  function automatic logic [7:0] byte_care(input logic [7:0] m, input logic hex);
    byte_care = hex ? {8{&m}} : m;
  endfunction : byte_care

  always_comb begin
    match = 1'b1;
    for (int i = 0; i < int'(i2c_mon_pkg::PAT_BYTES); i++) begin
      if (i < int'(byte_count)) begin
        if (|((window[i*8 +: 8] ^ value[i*8 +: 8]) & byte_care(care[i*8 +: 8], hex_mode))) begin
          match = 1'b0;
        end
      end
    end
  end

endmodule : pattern_match

/* tb/i2c_bus_model.sv */
// Behavioural master and slaves on the observed two-wire bus.
`timescale 1ns/10ps
module i2c_bus_model (
  // Observed bus levels
  output logic scl,
  output logic sda
);
  localparam realtime Q = 31.25;
  localparam realtime H = 62.5;
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Start or repeated start; the clock idles high and runs only inside frames.
  task automatic start_c();
    #Q sda = 1'b1;
    #Q scl = 1'b1;
    #H sda = 1'b0;
    #H scl = 1'b0;
  endtask : start_c
  // Sends the top n bits of v, most significant first; the ninth is the acknowledge slot.
  task automatic bits(input logic [8:0] v, input int n);
    for (int j = 8; j > 8 - n; j--) begin
      #Q sda = v[j];
      #Q scl = 1'b1;
      #H scl = 1'b0;
      if (j == 0) begin
        #Q sda = 1'b1;
      end
    end
  endtask : bits
  task automatic stop_c();
    #Q sda = 1'b0;
    #Q scl = 1'b1;
    #H sda = 1'b1;
    #H;
  endtask : stop_c
endmodule : i2c_bus_model

/* tb/i2c_bus_trigger_decoder_asserts.sv */
// Concurrent checks on the decoder's register bus and bus-event outputs.
`timescale 1ns/10ps
module i2c_bus_trigger_decoder_asserts (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [i2c_mon_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Observed bus
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic capture_active,
  // Results
  input wire logic trigger,
  input wire logic record_valid
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the trigger mode and the age of the last stop seen on the pins.
  typedef struct packed {
    logic [2:0] mode;
    logic sda_q;
    logic [3:0] stop_age;
  } shadow_s;
  shadow_s st;
  shadow_s next_st;
  logic done;
  assign done = psel && penable && pready;
  always_comb begin
    next_st = st;
    next_st.sda_q = sda_in;
    if (scl_in && sda_in && !st.sda_q) begin
      next_st.stop_age = 4'h0;
    end else if (st.stop_age != 4'hf) begin
      next_st.stop_age = st.stop_age + 4'h1;
    end
    if (done && pwrite && paddr == i2c_mon_pkg::OFS_CTRL) begin
      next_st.mode = pwdata[2:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{mode: i2c_mon_pkg::CTRL_RESET[2:0], sda_q: 1'b1, stop_age: 4'hf};
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_start;
    scl_in && $fell(sda_in);
  endsequence
  sequence s_stop;
    scl_in && $rose(sda_in);
  endsequence

  a_ready_timing: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_err_unmapped: assert property (done && paddr > i2c_mon_pkg::OFS_REC2 |-> pslverr)
    else $error("no slave error");
  a_err_read: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("bad error read");
  a_prdata_hold: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("prdata moved");
  a_start_trig: assert property (st.mode == i2c_mon_pkg::MODE_START ##0 s_start |-> ##[2:7] trigger)
    else $error("start missed");
  a_stop_trig: assert property (st.mode == i2c_mon_pkg::MODE_STOP ##0 s_stop |-> ##[2:7] trigger)
    else $error("stop missed");
  a_stop_only: assert property (trigger && st.mode == i2c_mon_pkg::MODE_STOP |-> st.stop_age < 4'h9)
    else $error("stray stop trigger");
  a_close_rec: assert property (s_stop |-> ##[2:8] record_valid)
    else $error("record not held");
  a_rec_clear: assert property (done && !pwrite && paddr == i2c_mon_pkg::OFS_REC2 |=> !record_valid)
    else $error("record not cleared");
  a_trig_pulse: assert property (trigger |=> !trigger)
    else $error("trigger too long");
endmodule : i2c_bus_trigger_decoder_asserts

bind i2c_bus_trigger_decoder i2c_bus_trigger_decoder_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .scl_in(scl_in), .sda_in(sda_in), .capture_active(capture_active), .trigger(trigger),
  .record_valid(record_valid)
);

/* tb/i2c_bus_trigger_decoder_tb_top.sv */
// Self-checking bench for the I2C bus trigger decoder.
`timescale 1ns/10ps
module i2c_bus_trigger_decoder_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic scl;
  logic sda;
  logic capture_active = 1'b1;
  logic trigger;
  logic record_valid;
  logic [31:0] rd;
  logic [31:0] rec;
  logic [31:0] rec1;
  logic err;
  int n_fail = 0;
  int total_checks = 0;
  int trig_seen = 0;
  localparam logic [71:0] MIX = {9'h140, 9'h024, 9'h142, 9'h069, 36'h0};
  localparam logic [71:0] DAT = {9'h140, 9'h022, 9'h044, 9'h067, 36'h0};
  localparam logic [71:0] TEN = {9'h1e8, 9'h14a, 9'h006, 45'h0};
  localparam int MIX_EXP [4] = '{2, 1, 1, 1};
  localparam logic [23:0] PV [6] = '{24'h2233, 24'h2200, 24'h2234, 24'h22ff, 24'h22ff, 24'h2232};
  localparam logic [23:0] PM [6] = '{24'hffff, 24'hff00, 24'hffff, 24'hff0f, 24'hff0f, 24'hfffe};
  localparam bit [5:0] HX = 6'b001000;
  localparam bit [5:0] EX = 6'b101011;

  i2c_bus_trigger_decoder DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_in(scl), .sda_in(sda), .capture_active(capture_active), .trigger(trigger),
    .record_valid(record_valid)
  );
  i2c_bus_model u_bus (
    .scl(scl),
    .sda(sda)
  );

  initial begin
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (trigger === 1'b1) begin
      trig_seen <= trig_seen + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [31:0] cw(input logic [2:0] m, input bit ten, input bit rdir,
                                     input bit dat, input bit incl, input logic [1:0] cnt,
                                     input bit hex);
    return {22'h0, hex, cnt, incl, dat, rdir, ten, m};
  endfunction : cw

  // Sends one frame of n units, a repeated start before unit rs, lastn bits in the last unit.
  task automatic run(input logic [31:0] ctrl, input logic [71:0] us, input int n,
                     input int rs, input int lastn, input int exp_trig);
    int b;
    int k;
    apb(1'b1, i2c_mon_pkg::OFS_CTRL, ctrl);
    b = trig_seen;
    u_bus.start_c();
    for (int i = 0; i < n; i++) begin
      if (i == rs) begin
        u_bus.start_c();
      end
      u_bus.bits(us[71-9*i -: 9], (i == n - 1) ? lastn : 9);
    end
    u_bus.stop_c();
    k = 0;
    while (record_valid !== 1'b1 && k < 100) begin
      @(posedge pclk);
      k++;
    end
    if (record_valid !== 1'b1) begin
      n_fail++;
      close_out();
    end
    apb(1'b0, i2c_mon_pkg::OFS_REC0, 32'h0);
    rec = rd;
    apb(1'b0, i2c_mon_pkg::OFS_REC1, 32'h0);
    rec1 = rd;
    apb(1'b0, i2c_mon_pkg::OFS_REC2, 32'h0);
    chk("triggers", exp_trig, trig_seen - b);
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #500us;
    n_fail++;
    close_out();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, i2c_mon_pkg::OFS_CTRL, 32'h0);
    chk("ctrl", {22'h0, i2c_mon_pkg::CTRL_RESET}, rd);
    apb(1'b0, i2c_mon_pkg::OFS_STATUS, 32'h0);
    chk("status", 32'h0, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    chk("unmapped", 32'h0, rd);
    apb(1'b1, i2c_mon_pkg::OFS_TARGET, 32'hffffffff);
    apb(1'b0, i2c_mon_pkg::OFS_TARGET, 32'h0);
    chk("target", 32'h3ff, rd);
    apb(1'b1, i2c_mon_pkg::OFS_OFFSET, 32'hffffffff);
    apb(1'b0, i2c_mon_pkg::OFS_OFFSET, 32'h0);
    chk("offset", 32'hfff, rd);
    apb(1'b1, i2c_mon_pkg::OFS_CTRL, cw(3'h0, 0, 0, 0, 0, 2'h0, 0));
    apb(1'b0, i2c_mon_pkg::OFS_CTRL, 32'h0);
    chk("count", 32'h1, {30'h0, rd[8:7]});
    for (int m = 0; m < 4; m++) begin
      run(cw(3'(m), 0, 0, 0, 0, 2'h1, 0), MIX, 4, 2, 9, MIX_EXP[m]);
    end
    chk("rec0", 32'h4504, rec);
    chk("rec1", 32'h34, {24'h0, rec1[7:0]});
    chk("time sign", 32'h1, {31'h0, rd[31]});
    apb(1'b1, i2c_mon_pkg::OFS_TARGET, 32'h50);
    run(cw(i2c_mon_pkg::MODE_ADDR, 0, 1, 0, 1, 2'h1, 0), MIX, 4, 2, 9, 1);
    chk("rec0 rw", 32'h4a14, rec);
    run(cw(i2c_mon_pkg::MODE_ADDR, 0, 0, 0, 0, 2'h1, 0), MIX, 4, 2, 9, 1);
    apb(1'b1, i2c_mon_pkg::OFS_TARGET, 32'h51);
    run(cw(i2c_mon_pkg::MODE_ADDR, 0, 1, 0, 0, 2'h1, 0), MIX, 4, 2, 9, 0);
    apb(1'b1, i2c_mon_pkg::OFS_TARGET, 32'h50);
    apb(1'b1, i2c_mon_pkg::OFS_OFFSET, 32'h1);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, i2c_mon_pkg::OFS_PVAL, {8'h0, PV[i]});
      apb(1'b1, i2c_mon_pkg::OFS_PMASK, {8'h0, PM[i]});
      run(cw(i2c_mon_pkg::MODE_ADDR, 0, 0, 1, 0, 2'h2, HX[i]), DAT, 4, -1, 9, EX[i]);
    end
    apb(1'b1, i2c_mon_pkg::OFS_TARGET, 32'h2a5);
    run(cw(i2c_mon_pkg::MODE_ADDR, 1, 0, 0, 0, 2'h1, 0), TEN, 3, -1, 9, 1);
    chk("rec0 ten", 32'h6a58, rec);
    @(posedge pclk);
    capture_active <= 1'b0;
    run(cw(3'h0, 0, 0, 0, 0, 2'h1, 0), 72'h0, 0, -1, 9, 1);
    chk("code", {30'h0, i2c_mon_pkg::CODE_NO_DATA}, {30'h0, rec[1:0]});
    run(cw(3'h0, 0, 0, 0, 0, 2'h1, 0), MIX, 1, -1, 9, 1);
    chk("code", {30'h0, i2c_mon_pkg::CODE_PARTIAL}, {30'h0, rec[1:0]});
    @(posedge pclk);
    capture_active <= 1'b1;
    run(cw(3'h0, 0, 0, 0, 0, 2'h1, 0), MIX, 1, -1, 4, 1);
    chk("code", {30'h0, i2c_mon_pkg::CODE_ADDR_ERR}, {30'h0, rec[1:0]});
    close_out();
  end
endmodule : i2c_bus_trigger_decoder_tb_top
